// file: verilog/irq_pin_mux.sv
// Interrupt pulse outputs, sticky flags and pin function multiplexer.
// Assumes a synchronous byte-wide register port and core-clock inputs.
//
// Function
// - Control A over-current enable lets over-current events trigger output A.
// - Control A DSP enable lets DSP interrupt events trigger output A.
// - Control A mode 0: one active-high 2 ms pulse per event.
// - Control A mode 1: repeating 2 ms pulses until sticky 1 or 2 read.
// - Control B over-current enable lets over-current events trigger output B.
// - Control B DSP enable lets DSP interrupt events trigger output B.
// - Control B mode 0: one active-high 2 ms pulse per event.
// - Control B mode 1: repeating 2 ms pulses until sticky 1 or 2 read.
// - Pin code 0000 disables pin; 0001 routes pin input to secondary interface.
// - Pin code 0010 makes the pin a general-purpose input.
// - Pin control bit 1 reads the sampled pin level.
// - Codes 0011, 0101, 0110 drive clock tap, output A, output B.
// - Code 0111 drives secondary bit clock, 1000 secondary word clock.
// - Code 1010 drives 0; 1011 drives serial audio data out.
// - General-purpose output mode drives pin control bit 0.
// - DSP overflow sticky flag holds until its register is read.
// - Over-current sticky flag clears on read; read also ends pulse trains.
// - DSP standard and auxiliary interrupt ports are sticky in flag register 2.
`timescale 1ns/10ps
module irq_pin_mux #(
  parameter int PULSE_CYCLES = irq_pin_pkg::PULSE_CYCLES
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // Register port
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // Event sources
  input wire logic i_hp_overcurrent,
  input wire logic i_dsp_irq_std,
  input wire logic i_dsp_irq_aux,
  input wire logic i_dsp_overflow,
  // Pin sources
  input wire logic i_clock_output_tap_tap,
  input wire logic i_sec_bclk,
  input wire logic i_sec_wclk,
  input wire logic i_sdout,
  // Pin
  input wire logic i_gpio_in,
  output logic o_gpio_out,
  output logic o_gpio_oe,
  // Secondary input route
  output logic o_sec_in,
  output logic o_sec_in_en,
  // Interrupts
  output logic o_irq_a,
  output logic o_irq_b
);
  // ==========================================================
  // State
  logic [7:0] ctl_a_reg;
  logic [7:0] ctl_a_next;
  logic [7:0] ctl_b_reg;
  logic [7:0] ctl_b_next;
  logic [7:0] pin_reg;
  logic [7:0] pin_next;
  logic [7:0] sticky1_reg;
  logic [7:0] sticky1_next;
  logic [7:0] sticky2_reg;
  logic [7:0] sticky2_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic oc_d_reg;
  logic dsp_d_reg;
  logic gpio_in_reg;
  logic gout_reg;
  logic gout_next;
  logic goe_reg;
  logic goe_next;
  logic sec_in_reg;
  logic sec_en_reg;
  logic sec_en_next;
  logic oc_edge;
  logic dsp_edge;
  logic trig_a;
  logic trig_b;
  logic stop_train;
  logic rd_st1;
  logic rd_st2;
  logic [3:0] fn;

  function automatic logic [7:0] wr_field(input logic [7:0] old, input logic [7:0] wd,
                                          input logic [7:0] mask);
    wr_field = (old & ~mask) | (wd & mask);
  endfunction : wr_field

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction : hit

  // ==========================================================
  // Event detection and triggers
  assign oc_edge = i_hp_overcurrent && !oc_d_reg;
  assign dsp_edge = (i_dsp_irq_std || i_dsp_irq_aux) && !dsp_d_reg;
  assign trig_a = (ctl_a_reg[irq_pin_pkg::CTL_OC_EN] && oc_edge)
    || (ctl_a_reg[irq_pin_pkg::CTL_DSP_EN] && dsp_edge);
  assign trig_b = (ctl_b_reg[irq_pin_pkg::CTL_OC_EN] && oc_edge)
    || (ctl_b_reg[irq_pin_pkg::CTL_DSP_EN] && dsp_edge);
  assign rd_st1 = i_reg_rd && hit(i_reg_addr, irq_pin_pkg::OFF_STICKY_1);
  assign rd_st2 = i_reg_rd && hit(i_reg_addr, irq_pin_pkg::OFF_STICKY_2);
  assign stop_train = rd_st1 || rd_st2;
  assign fn = pin_reg[irq_pin_pkg::PIN_FN_LSB +: 4];

  // ==========================================================
  // Pulse generators
  irq_pulse_gen #(
    .PULSE_CYCLES(PULSE_CYCLES)
  ) u_gen_a (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_trig(trig_a),
    .i_multi(ctl_a_reg[irq_pin_pkg::CTL_MULTI]),
    .i_stop(stop_train),
    .o_pulse(o_irq_a)
  );

  irq_pulse_gen #(
    .PULSE_CYCLES(PULSE_CYCLES)
  ) u_gen_b (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_trig(trig_b),
    .i_multi(ctl_b_reg[irq_pin_pkg::CTL_MULTI]),
    .i_stop(stop_train),
    .o_pulse(o_irq_b)
  );

  // ==========================================================
  // Registers and sticky flags
  always_comb begin
    ctl_a_next = ctl_a_reg;
    ctl_b_next = ctl_b_reg;
    pin_next = pin_reg;
    rdata_next = rdata_reg;
    if (i_reg_wr && hit(i_reg_addr, irq_pin_pkg::OFF_IRQ_A_CTL)) begin
      ctl_a_next = wr_field(ctl_a_reg, i_reg_wdata, irq_pin_pkg::CTL_WMASK);
    end
    if (i_reg_wr && hit(i_reg_addr, irq_pin_pkg::OFF_IRQ_B_CTL)) begin
      ctl_b_next = wr_field(ctl_b_reg, i_reg_wdata, irq_pin_pkg::CTL_WMASK);
    end
    if (i_reg_wr && hit(i_reg_addr, irq_pin_pkg::OFF_PIN_CTL)) begin
      pin_next = wr_field(pin_reg, i_reg_wdata, irq_pin_pkg::PIN_WMASK);
    end
    // Set wins over clear on read
    sticky1_next = sticky1_reg & ~{8{rd_st1}};
    sticky1_next[irq_pin_pkg::ST1_DSP_OVF] = sticky1_next[irq_pin_pkg::ST1_DSP_OVF]
      | i_dsp_overflow;
    sticky2_next = sticky2_reg & ~{8{rd_st2}};
    sticky2_next[irq_pin_pkg::ST2_HP_OC] = sticky2_next[irq_pin_pkg::ST2_HP_OC]
      | i_hp_overcurrent;
    sticky2_next[irq_pin_pkg::ST2_DSP_STD] = sticky2_next[irq_pin_pkg::ST2_DSP_STD]
      | i_dsp_irq_std;
    sticky2_next[irq_pin_pkg::ST2_DSP_AUX] = sticky2_next[irq_pin_pkg::ST2_DSP_AUX]
      | i_dsp_irq_aux;
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        irq_pin_pkg::OFF_STICKY_1: rdata_next = sticky1_reg;
        irq_pin_pkg::OFF_STICKY_2: rdata_next = sticky2_reg;
        irq_pin_pkg::OFF_IRQ_A_CTL: rdata_next = ctl_a_reg;
        irq_pin_pkg::OFF_IRQ_B_CTL: rdata_next = ctl_b_reg;
        irq_pin_pkg::OFF_PIN_CTL: begin
          rdata_next = pin_reg;
          rdata_next[irq_pin_pkg::PIN_IN_BIT] = gpio_in_reg;
        end
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // ==========================================================
  // Pin multiplexer
  always_comb begin
    gout_next = 1'b0;
    goe_next = 1'b1;
    sec_en_next = 1'b0;
    unique case (fn)
      irq_pin_pkg::FN_OFF: goe_next = 1'b0;
      irq_pin_pkg::FN_SEC_IN: begin
        goe_next = 1'b0;
        sec_en_next = 1'b1;
      end
      irq_pin_pkg::FN_GPI: goe_next = 1'b0;
      irq_pin_pkg::FN_CLOCK_OUTPUT_TAP: gout_next = i_clock_output_tap_tap;
      irq_pin_pkg::FN_GPO: gout_next = pin_reg[irq_pin_pkg::PIN_GPO_BIT];
      irq_pin_pkg::FN_IRQ_A: gout_next = o_irq_a;
      irq_pin_pkg::FN_IRQ_B: gout_next = o_irq_b;
      irq_pin_pkg::FN_SEC_BCLK: gout_next = i_sec_bclk;
      irq_pin_pkg::FN_SEC_WCLK: gout_next = i_sec_wclk;
      irq_pin_pkg::FN_ZERO: gout_next = 1'b0;
      irq_pin_pkg::FN_SDOUT: gout_next = i_sdout;
      default: goe_next = 1'b0;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctl_a_reg <= irq_pin_pkg::CTL_RESET;
      ctl_b_reg <= irq_pin_pkg::CTL_RESET;
      pin_reg <= irq_pin_pkg::PIN_RESET;
      sticky1_reg <= irq_pin_pkg::STICKY_RESET;
      sticky2_reg <= irq_pin_pkg::STICKY_RESET;
      rdata_reg <= 8'h00;
      oc_d_reg <= 1'b0;
      dsp_d_reg <= 1'b0;
      gpio_in_reg <= 1'b0;
      gout_reg <= 1'b0;
      goe_reg <= 1'b0;
      sec_in_reg <= 1'b0;
      sec_en_reg <= 1'b0;
    end else begin
      ctl_a_reg <= ctl_a_next;
      ctl_b_reg <= ctl_b_next;
      pin_reg <= pin_next;
      sticky1_reg <= sticky1_next;
      sticky2_reg <= sticky2_next;
      rdata_reg <= rdata_next;
      oc_d_reg <= i_hp_overcurrent;
      dsp_d_reg <= i_dsp_irq_std || i_dsp_irq_aux;
      gpio_in_reg <= i_gpio_in;
      gout_reg <= gout_next;
      goe_reg <= goe_next;
      sec_in_reg <= i_gpio_in;
      sec_en_reg <= sec_en_next;
    end
  end

  assign o_reg_rdata = rdata_reg;
  assign o_gpio_out = gout_reg;
  assign o_gpio_oe = goe_reg;
  assign o_sec_in = sec_in_reg;
  assign o_sec_in_en = sec_en_reg;

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_b);

  property p_quiet_a;
    !ctl_a_reg[irq_pin_pkg::CTL_OC_EN] && !ctl_a_reg[irq_pin_pkg::CTL_DSP_EN] && !o_irq_a
      && !ctl_a_reg[irq_pin_pkg::CTL_MULTI] |=> !o_irq_a;
  endproperty
  a_quiet_a: assert property (p_quiet_a) else $error("output A fired while disabled");

  property p_quiet_b;
    !ctl_b_reg[irq_pin_pkg::CTL_OC_EN] && !ctl_b_reg[irq_pin_pkg::CTL_DSP_EN] && !o_irq_b
      && !ctl_b_reg[irq_pin_pkg::CTL_MULTI] |=> !o_irq_b;
  endproperty
  a_quiet_b: assert property (p_quiet_b) else $error("output B fired while disabled");

  property p_oc_fires_b;
    ctl_b_reg[irq_pin_pkg::CTL_OC_EN] && oc_edge && !o_irq_b
      && !ctl_b_reg[irq_pin_pkg::CTL_MULTI] && !$past(ctl_b_reg[irq_pin_pkg::CTL_MULTI])
      |=> o_irq_b;
  endproperty
  a_oc_fires_b: assert property (p_oc_fires_b) else $error("output B missed event");

  property p_dsp_fires_a;
    ctl_a_reg[irq_pin_pkg::CTL_DSP_EN] && dsp_edge && !o_irq_a
      && !ctl_a_reg[irq_pin_pkg::CTL_MULTI] && !$past(ctl_a_reg[irq_pin_pkg::CTL_MULTI])
      |=> o_irq_a;
  endproperty
  a_dsp_fires_a: assert property (p_dsp_fires_a) else $error("output A missed event");

  property p_sticky_set;
    i_hp_overcurrent |=> sticky2_reg[irq_pin_pkg::ST2_HP_OC];
  endproperty
  a_sticky_set: assert property (p_sticky_set) else $error("over-current flag lost");

  property p_sticky_clr;
    rd_st1 && !i_dsp_overflow |=> !sticky1_reg[irq_pin_pkg::ST1_DSP_OVF];
  endproperty
  a_sticky_clr: assert property (p_sticky_clr) else $error("overflow flag not cleared");

  property p_gpo;
    fn == irq_pin_pkg::FN_GPO |=> o_gpio_oe && o_gpio_out == $past(pin_reg[0]);
  endproperty
  a_gpo: assert property (p_gpo) else $error("pin output value wrong");

  property p_zero;
    fn == irq_pin_pkg::FN_ZERO |=> o_gpio_oe && !o_gpio_out;
  endproperty
  a_zero: assert property (p_zero) else $error("pin not held low");

  property p_undriven;
    fn inside {4'h0, 4'h1, 4'h2, 4'h9, 4'hC, 4'hD, 4'hE, 4'hF} |=> !o_gpio_oe;
  endproperty
  a_undriven: assert property (p_undriven) else $error("pin driven when disabled");

  property p_pin_read;
    i_reg_rd && hit(i_reg_addr, irq_pin_pkg::OFF_PIN_CTL) |=> o_reg_rdata[1] == $past(gpio_in_reg);
  endproperty
  a_pin_read: assert property (p_pin_read) else $error("pin level read wrong");

  c_pulse_a: cover property (trig_a && !ctl_a_reg[irq_pin_pkg::CTL_MULTI]);
  c_stop_b: cover property (o_irq_b && stop_train && ctl_b_reg[irq_pin_pkg::CTL_MULTI]);
  c_irq_on_pin: cover property (fn == irq_pin_pkg::FN_IRQ_A && o_gpio_out);
endmodule : irq_pin_mux

// file: verilog/irq_pin_pkg.sv
// Constants for the interrupt pulse and pin function block.
// Assumes an 8-bit register port with byte offsets as printed.
package irq_pin_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFF_STICKY_1 = 8'h2A;
  localparam logic [7:0] OFF_STICKY_2 = 8'h2C;
  localparam logic [7:0] OFF_RSVD_A = 8'h2F;
  localparam logic [7:0] OFF_IRQ_A_CTL = 8'h30;
  localparam logic [7:0] OFF_IRQ_B_CTL = 8'h31;
  localparam logic [7:0] OFF_RSVD_B = 8'h32;
  localparam logic [7:0] OFF_RSVD_C = 8'h33;
  localparam logic [7:0] OFF_PIN_CTL = 8'h34;
  // ==========================================================
  // Field positions
  localparam int CTL_OC_EN = 3;
  localparam int CTL_DSP_EN = 2;
  localparam int CTL_MULTI = 0;
  localparam int PIN_FN_LSB = 2;
  localparam int PIN_IN_BIT = 1;
  localparam int PIN_GPO_BIT = 0;
  localparam int ST1_DSP_OVF = 5;
  localparam int ST2_HP_OC = 7;
  localparam int ST2_DSP_STD = 1;
  localparam int ST2_DSP_AUX = 0;
  // ==========================================================
  // Writable masks and reset values
  localparam logic [7:0] CTL_WMASK = 8'h0D;
  localparam logic [7:0] PIN_WMASK = 8'h3D;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] PIN_RESET = 8'h00;
  localparam logic [7:0] STICKY_RESET = 8'h00;
  // ==========================================================
  // Pin function codes
  localparam logic [3:0] FN_OFF = 4'h0;
  localparam logic [3:0] FN_SEC_IN = 4'h1;
  localparam logic [3:0] FN_GPI = 4'h2;
  localparam logic [3:0] FN_CLOCK_OUTPUT_TAP = 4'h3;
  localparam logic [3:0] FN_GPO = 4'h4;
  localparam logic [3:0] FN_IRQ_A = 4'h5;
  localparam logic [3:0] FN_IRQ_B = 4'h6;
  localparam logic [3:0] FN_SEC_BCLK = 4'h7;
  localparam logic [3:0] FN_SEC_WCLK = 4'h8;
  localparam logic [3:0] FN_ZERO = 4'hA;
  localparam logic [3:0] FN_SDOUT = 4'hB;
  // ==========================================================
  // Timing
  localparam int CLK_HZ = 25_000_000;
  localparam int PULSE_US = 2000;
  localparam int PULSE_CYCLES = PULSE_US * (CLK_HZ / 1_000_000);
endpackage : irq_pin_pkg

// file: verilog/irq_pulse_gen.sv
// Pulse generator for one interrupt output: single pulse or train.
// Assumes trigger and stop are one-cycle pulses on the core clock.
`timescale 1ns/10ps
module irq_pulse_gen #(
  parameter int PULSE_CYCLES = 50000
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // Control
  input wire logic i_trig,
  input wire logic i_multi,
  input wire logic i_stop,
  // Output
  output logic o_pulse
);
  localparam int CW = $clog2(PULSE_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(PULSE_CYCLES - 1);

  typedef enum logic [1:0] {ST_IDLE, ST_HIGH, ST_LOW} pulse_state_t;

  pulse_state_t state_reg;
  pulse_state_t state_next;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic pulse_reg;
  logic pulse_next;

  // ==========================================================
  // Sequencer
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (i_trig) begin
          state_next = ST_HIGH;
          cnt_next = '0;
        end
      end
      ST_HIGH: begin
        if (i_multi && i_stop) begin
          state_next = ST_IDLE;
        end else if (cnt_reg == LAST) begin
          state_next = i_multi ? ST_LOW : ST_IDLE;
          cnt_next = '0;
        end else begin
          cnt_next = cnt_reg + CW'(1);
        end
      end
      ST_LOW: begin
        if (i_stop || !i_multi) begin
          state_next = ST_IDLE;
        end else if (cnt_reg == LAST) begin
          state_next = ST_HIGH;
          cnt_next = '0;
        end else begin
          cnt_next = cnt_reg + CW'(1);
        end
      end
    endcase
    pulse_next = (state_next == ST_HIGH);
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= ST_IDLE;
      cnt_reg <= '0;
      pulse_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      pulse_reg <= pulse_next;
    end
  end

  assign o_pulse = pulse_reg;

  // ==========================================================
  // Checks
  logic [CW-1:0] hi_cnt_reg;
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hi_cnt_reg <= '0;
    end else begin
      hi_cnt_reg <= pulse_reg ? hi_cnt_reg + CW'(1) : '0;
    end
  end

  property p_start;
    @(posedge i_core_clk) disable iff (!i_rst_b)
      (state_reg == ST_IDLE) && i_trig |=> pulse_reg;
  endproperty
  a_start: assert property (p_start) else $error("pulse did not start");

  property p_high_len;
    @(posedge i_core_clk) disable iff (!i_rst_b)
      pulse_reg |-> hi_cnt_reg < CW'(PULSE_CYCLES);
  endproperty
  a_high_len: assert property (p_high_len) else $error("pulse too long");

  property p_full_len;
    @(posedge i_core_clk) disable iff (!i_rst_b)
      $fell(pulse_reg) && !$past(i_stop) |-> $past(hi_cnt_reg) == LAST;
  endproperty
  a_full_len: assert property (p_full_len) else $error("pulse too short");

  property p_stop;
    @(posedge i_core_clk) disable iff (!i_rst_b)
      i_multi && i_stop && (state_reg != ST_IDLE)
        |=> !pulse_reg ##1 (!pulse_reg || $past(i_trig));
  endproperty
  a_stop: assert property (p_stop) else $error("train not stopped");

  property p_single_once;
    @(posedge i_core_clk) disable iff (!i_rst_b)
      !i_multi && $fell(pulse_reg) && !i_trig |=> !pulse_reg;
  endproperty
  a_single_once: assert property (p_single_once) else $error("single repeated");

  c_train: cover property (@(posedge i_core_clk) i_multi && $rose(pulse_reg) && state_reg == ST_HIGH
    && cnt_reg == '0 && $past(state_reg) == ST_LOW);
endmodule : irq_pulse_gen

// file: verif/host_model.sv
// Host processor model: byte-wide register reads and writes.
// Assumes core-clock timing; tasks are called from the bench.
`timescale 1ns/10ps
module host_model (
  // Clock
  input wire logic i_core_clk,
  // Register port
  output logic [7:0] o_reg_addr,
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic [7:0] o_reg_wdata
);
  // ==========================================================
  // Idle bus
  initial begin
    o_reg_addr = 8'hFF;
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_wdata = 8'h00;
  end

  // ==========================================================
  // Bus cycles
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    logic [7:0] d;
    d = data;
    if (addr inside {irq_pin_pkg::OFF_RSVD_A, irq_pin_pkg::OFF_RSVD_B,
                     irq_pin_pkg::OFF_RSVD_C}) begin
      d = 8'h00;
    end
    if (addr == irq_pin_pkg::OFF_PIN_CTL && d[5:2] == 4'hF) begin
      d[5:2] = irq_pin_pkg::FN_OFF;
    end
    @(posedge i_core_clk);
    #1;
    o_reg_addr = addr;
    o_reg_wdata = d;
    o_reg_wr = 1'b1;
    @(posedge i_core_clk);
    #1;
    o_reg_wr = 1'b0;
    o_reg_addr = ~addr;
    o_reg_wdata = ~d;
  endtask : wr

  // Sticky reads also end pulse trains
  task automatic rd(input logic [7:0] addr);
    @(posedge i_core_clk);
    #1;
    o_reg_addr = addr;
    o_reg_rd = 1'b1;
    @(posedge i_core_clk);
    #1;
    o_reg_rd = 1'b0;
    o_reg_addr = ~addr;
  endtask : rd
endmodule : host_model

// file: verif/tb_top.sv
// Testbench: registers, interrupt pulses and pin function mux.
// Assumes host_model drives the register port.
`timescale 1ns/10ps
module tb_top;
  localparam int P = 10;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_wr;
  logic reg_rd;
  logic hp_oc = 1'b0;
  logic dsp_std = 1'b0;
  logic dsp_aux = 1'b0;
  logic dsp_ovf = 1'b0;
  logic clk_tap = 1'b0;
  logic bclk = 1'b0;
  logic wclk = 1'b0;
  logic sdout = 1'b0;
  logic gpio_in = 1'b0;
  logic gpio_out;
  logic gpio_oe;
  logic sec_in;
  logic sec_in_en;
  logic irq_a;
  logic irq_b;
  int errors = 0;
  int n_compared = 0;
  int seed = 92;
  int cycles = 0;
  int rise_a;
  int rise_b;
  int hi_a;
  int hi_b;
  int ev;
  logic [7:0] exp_q[$];
  logic rd_seen = 1'b0;
  logic [7:0] ctl_a;
  logic [7:0] ctl_b;
  logic [7:0] pin;
  logic [1:0] ep;
  logic ea;
  logic eb;

  always #20 core_clk = ~core_clk;

  host_model host_u (
    .i_core_clk(core_clk),
    .o_reg_addr(reg_addr),
    .o_reg_wr(reg_wr),
    .o_reg_rd(reg_rd),
    .o_reg_wdata(reg_wdata)
  );

  irq_pin_mux #(.PULSE_CYCLES(P)) dut_u (
    .i_core_clk(core_clk),
    .i_rst_b(rst_b),
    .i_reg_addr(reg_addr),
    .i_reg_wr(reg_wr),
    .i_reg_rd(reg_rd),
    .i_reg_wdata(reg_wdata),
    .o_reg_rdata(reg_rdata),
    .i_hp_overcurrent(hp_oc),
    .i_dsp_irq_std(dsp_std),
    .i_dsp_irq_aux(dsp_aux),
    .i_dsp_overflow(dsp_ovf),
    .i_clock_output_tap_tap(clk_tap),
    .i_sec_bclk(bclk),
    .i_sec_wclk(wclk),
    .i_sdout(sdout),
    .i_gpio_in(gpio_in),
    .o_gpio_out(gpio_out),
    .o_gpio_oe(gpio_oe),
    .o_sec_in(sec_in),
    .o_sec_in_en(sec_in_en),
    .o_irq_a(irq_a),
    .o_irq_b(irq_b)
  );

  // ==========================================================
  // Checking helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic summarize;
    $display("compared=%0d errors=%0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize

  task automatic rd_exp(input logic [7:0] addr, input logic [7:0] exp);
    exp_q.push_back(exp);
    host_u.rd(addr);
  endtask : rd_exp

  // Raise one event for a cycle (none for e = 3), then count output pulses
  task automatic run(input int e, input int n);
    logic pa;
    logic pb;
    pa = irq_a;
    pb = irq_b;
    {rise_a, rise_b, hi_a, hi_b} = {4{32'd0}};
    @(posedge core_clk);
    #1;
    {hp_oc, dsp_std, dsp_aux, dsp_ovf} = {e == 0, e == 1, e == 2, e == 4};
    repeat (n) begin
      @(posedge core_clk);
      #1;
      {hp_oc, dsp_std, dsp_aux, dsp_ovf} = 4'h0;
      if (irq_a === 1'b1 && pa !== 1'b1) rise_a++;
      if (irq_b === 1'b1 && pb !== 1'b1) rise_b++;
      if (irq_a === 1'b1) hi_a++;
      if (irq_b === 1'b1) hi_b++;
      pa = irq_a;
      pb = irq_b;
    end
  endtask : run

  // Expected {oe, out} per pin code
  function automatic logic [1:0] exp_pin(input logic [3:0] c, input logic gpo);
    case (c)
      4'h3: exp_pin = {1'b1, clk_tap};
      4'h4: exp_pin = {1'b1, gpo};
      4'h5, 4'h6, 4'hA: exp_pin = 2'h2;
      4'h7: exp_pin = {1'b1, bclk};
      4'h8: exp_pin = {1'b1, wclk};
      4'hB: exp_pin = {1'b1, sdout};
      default: exp_pin = 2'h0;
    endcase
  endfunction : exp_pin

  // ==========================================================
  // Read data monitor and timeout
  always @(posedge core_clk) begin
    if (rd_seen) begin
      if (exp_q.size() == 0) chk(reg_rdata, 8'hEE);
      else chk(reg_rdata, exp_q.pop_front());
    end
    rd_seen = reg_rd;
    cycles++;
    if (cycles == 8000) begin
      errors++;
      summarize();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (8) @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    for (int i = 0; i < 8; i++) rd_exp(8'h2A + 8'(i), 8'h00);
    host_u.wr(8'h40, 8'hFF);
    rd_exp(8'h40, 8'h00);
    host_u.wr(irq_pin_pkg::OFF_IRQ_A_CTL, 8'h0D);
    rd_exp(irq_pin_pkg::OFF_IRQ_A_CTL, 8'h0D);
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      ctl_a = (i == 0) ? 8'h0C : 8'($random(seed)) & 8'h0C;
      ctl_b = (i == 0) ? 8'h0C : 8'($random(seed)) & 8'h0C;
      ev = $unsigned($random(seed)) % 3;
      host_u.wr(irq_pin_pkg::OFF_IRQ_A_CTL, ctl_a);
      host_u.wr(irq_pin_pkg::OFF_IRQ_B_CTL, ctl_b);
      run(ev, 3 * P);
      ea = (ev == 0) ? ctl_a[3] : ctl_a[2];
      eb = (ev == 0) ? ctl_b[3] : ctl_b[2];
      chk(8'(hi_a), ea ? 8'(P) : 8'h00);
      chk(8'(rise_a), {7'h00, ea});
      chk(8'(hi_b), eb ? 8'(P) : 8'h00);
      chk(8'(rise_b), {7'h00, eb});
      rd_exp(irq_pin_pkg::OFF_STICKY_2, 8'h80 >> (ev == 0 ? 0 : 5 + ev));
    end
    $display("test single pulses done");
    for (int k = 0; k < 2; k++) begin
      host_u.wr(irq_pin_pkg::OFF_IRQ_A_CTL, 8'h09);
      host_u.wr(irq_pin_pkg::OFF_IRQ_B_CTL, 8'h05);
      run(k, 5 * P);
      chk(8'(rise_a), k == 0 ? 8'h03 : 8'h00);
      chk(8'(rise_b), k == 1 ? 8'h03 : 8'h00);
      rd_exp(k == 0 ? irq_pin_pkg::OFF_STICKY_1 : irq_pin_pkg::OFF_STICKY_2,
             k == 0 ? 8'h00 : 8'h82);
      run(3, 3 * P);
      chk(8'(hi_a + hi_b), 8'h00);
    end
    host_u.wr(irq_pin_pkg::OFF_IRQ_A_CTL, 8'h00);
    host_u.wr(irq_pin_pkg::OFF_IRQ_B_CTL, 8'h00);
    run(4, 2);
    rd_exp(irq_pin_pkg::OFF_STICKY_1, 8'h20);
    rd_exp(irq_pin_pkg::OFF_STICKY_1, 8'h00);
    $display("test pulse trains done");
    for (int c = 0; c < 15; c++) begin
      {gpio_in, clk_tap, bclk, wclk, sdout} = 5'($random(seed));
      pin = {2'b00, 4'(c), 1'b0, 1'($random(seed))};
      host_u.wr(irq_pin_pkg::OFF_PIN_CTL, pin);
      repeat (3) @(posedge core_clk);
      #1;
      ep = exp_pin(4'(c), pin[0]);
      chk({7'h00, gpio_oe}, {7'h00, ep[1]});
      if (ep[1]) chk({7'h00, gpio_out}, {7'h00, ep[0]});
      chk({7'h00, sec_in_en}, {7'h00, c == 1});
      if (c == 1) chk({7'h00, sec_in}, {7'h00, gpio_in});
      rd_exp(irq_pin_pkg::OFF_PIN_CTL, pin | {6'h00, gpio_in, 1'b0});
    end
    host_u.wr(irq_pin_pkg::OFF_IRQ_A_CTL, 8'h08);
    host_u.wr(irq_pin_pkg::OFF_PIN_CTL, {2'b00, irq_pin_pkg::FN_IRQ_A, 2'b00});
    run(0, 4);
    chk({6'h00, gpio_oe, gpio_out}, 8'h03);
    repeat (3 * P) @(posedge core_clk);
    $display("test pin mux done");
    repeat (4) @(posedge core_clk);
    summarize();
  end
endmodule : tb_top
